// ---- logic/i2csp_params.svh ----
// Constants of the two-wire slave register port: addresses, commands, reset values and timing.
`ifndef I2CSP_PARAMS_SVH
`define I2CSP_PARAMS_SVH

// Start bytes that select this port, write and read.
`define I2CSP_START_WR      8'h90
`define I2CSP_START_RD      8'h91
// General call address byte, write direction.
`define I2CSP_START_GC      8'h00
// Pointer byte that acts as a soft reset command.
`define I2CSP_CMD_RESET     8'hBF
// General call command that resets the part.
`define I2CSP_GC_RESET      8'h06
// Pointer value after reset and after a stop: the status register.
`define I2CSP_PTR_RESET     8'h00
// Highest writable register address of the bank.
`define I2CSP_LAST_REG      8'h17
// Default reload time in nanoseconds, and the clock period.
`define I2CSP_RELOAD_NS     2000000
`define I2CSP_CLK_NS        10
`define I2CSP_RELOAD_CYCLES (`I2CSP_RELOAD_NS / `I2CSP_CLK_NS)

`endif

// ---- logic/i2csp_pkg.sv ----
// Types shared by the two-wire slave register port modules.
package i2csp_pkg;

   // Protocol phases of the slave engine.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RECV,
      ST_ACK,
      ST_SEND,
      ST_MACK,
      ST_RNEXT
   } i2csp_state_t;

   // Meaning of the byte being received.
   typedef enum logic [1:0] {
      K_ADDR,
      K_PTR,
      K_DATA,
      K_GC
   } i2csp_kind_t;

   // One write towards the register bank: address and data.
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } i2csp_wr_t;

   // Synchroniser state.
   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_d;
      logic sda_s1;
      logic sda_s2;
      logic sda_d;
   } i2csp_sync_t;

   // Engine state.
   typedef struct packed {
      i2csp_state_t st;
      i2csp_kind_t  kind;
      logic [3:0]   bitcnt;
      logic [7:0]   shreg;
      logic         rw;
      logic         after_ack;
      logic [7:0]   ptr;
      logic         sda_oe;
      logic         push_valid;
      i2csp_wr_t    push;
      logic         reload_req;
      logic         reload_busy;
      logic [23:0]  reload_cnt;
   } i2csp_core_t;

endpackage : i2csp_pkg

// ---- logic/i2csp_line_if.sv ----
// Bus line events passed from the synchroniser to the slave engine.
`timescale 1ns/10ps
interface i2csp_line_if;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;

   modport src (output sda, output scl_rise, output scl_fall, output start, output stop);
   modport dst (input sda, input scl_rise, input scl_fall, input start, input stop);
endinterface : i2csp_line_if

// ---- logic/i2csp_sync.sv ----
// Two-flop synchronisers for SCL and SDA with edge, start and stop detection.
`timescale 1ns/10ps
module i2csp_sync (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic ce,
   input  wire logic scl_in,
   input  wire logic sda_in,
   i2csp_line_if.src line
);
   import i2csp_pkg::*;

   i2csp_sync_t r;
   i2csp_sync_t next_r;

   // Lines idle high, so the flops reset high to avoid a false start at release.
   always_comb begin
      next_r        = r;
      next_r.scl_s1 = scl_in;
      next_r.scl_s2 = r.scl_s1;
      next_r.scl_d  = r.scl_s2;
      next_r.sda_s1 = sda_in;
      next_r.sda_s2 = r.sda_s1;
      next_r.sda_d  = r.sda_s2;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         r <= '1;
      end else if (ce) begin
         r <= next_r;
      end
   end

   // Edges are taken only from the second and third stages.
   assign line.sda      = r.sda_s2;
   assign line.scl_rise = r.scl_s2 & ~r.scl_d;
   assign line.scl_fall = ~r.scl_s2 & r.scl_d;
   assign line.start    = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
   assign line.stop     = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;

endmodule : i2csp_sync

// ---- logic/i2csp_buf.sv ----
// Two-entry buffer with valid and ready on both sides; the head is always a flop.
`timescale 1ns/10ps
module i2csp_buf #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         ce,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic         head_v;
   logic         tail_v;
   logic [W-1:0] head_d;
   logic [W-1:0] tail_d;
   logic         take;
   logic         give;

   assign take = in_valid & ~tail_v;
   assign give = head_v & out_ready;

   // The tail holds a word only while the head is occupied and stalled.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         head_v <= 1'b0;
         tail_v <= 1'b0;
         head_d <= '0;
         tail_d <= '0;
      end else if (ce) begin
         if (!head_v || give) begin
            head_v <= tail_v | take;
            head_d <= tail_v ? tail_d : in_data;
            tail_v <= tail_v & take;
            if (tail_v) begin
               tail_d <= in_data;
            end
         end else if (take) begin
            tail_v <= 1'b1;
            tail_d <= in_data;
         end
      end
   end

   assign in_ready  = ~tail_v;
   assign out_valid = head_v;
   assign out_data  = head_d;

endmodule : i2csp_buf

// ---- logic/i2csp_port.sv ----
// Two-wire slave engine: address match, pointer, reads, writes and reset commands.
`timescale 1ns/10ps
`include "i2csp_params.svh"
module i2csp_port #(
   parameter int RELOAD_CYCLES = `I2CSP_RELOAD_CYCLES,
   parameter logic [7:0] LAST_REG = `I2CSP_LAST_REG
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         ce,
   input  wire logic         scl_in,
   input  wire logic         sda_in,
   output logic              sda_out,
   output logic              sda_oe,
   output logic [7:0]        rd_addr,
   input  wire logic [7:0]   rd_data,
   output logic              wr_valid,
   input  wire logic         wr_ready,
   output i2csp_pkg::i2csp_wr_t wr_word,
   output logic              reload_req,
   output logic              reload_busy
);
   import i2csp_pkg::*;

   i2csp_core_t  r;
   i2csp_core_t  next_r;
   logic         buf_ready;
   logic         buf_out_valid;
   logic [15:0]  buf_out_data;

   i2csp_line_if line ();

   i2csp_sync u_sync (
      .clk    (clk),
      .resetn (resetn),
      .ce     (ce),
      .scl_in (scl_in),
      .sda_in (sda_in),
      .line   (line)
   );

   i2csp_buf #(.W(16)) u_buf (
      .clk       (clk),
      .resetn    (resetn),
      .ce        (ce),
      .in_valid  (r.push_valid),
      .in_ready  (buf_ready),
      .in_data   (r.push),
      .out_valid (buf_out_valid),
      .out_ready (wr_ready),
      .out_data  (buf_out_data)
   );

   // True when a write to this address is stored in the bank.
   function automatic logic reg_writable(input logic [7:0] a);
      reg_writable = (a <= LAST_REG);
   endfunction : reg_writable

   // Begins a reload: pulse the bank, block acknowledges, clear the pointer.
   function automatic i2csp_core_t start_reload(input i2csp_core_t s);
      i2csp_core_t t;
      t             = s;
      t.reload_req  = 1'b1;
      t.reload_busy = 1'b1;
      t.reload_cnt  = 24'(RELOAD_CYCLES);
      t.ptr         = `I2CSP_PTR_RESET;
      return t;
   endfunction : start_reload

   // Loads a read byte: bit 7 is driven at once, the rest waits in the shifter.
   function automatic i2csp_core_t send_load(input i2csp_core_t s, input logic [7:0] d);
      i2csp_core_t t;
      t        = s;
      t.shreg  = {d[6:0], 1'b0};
      t.sda_oe = ~d[7];
      t.bitcnt = 4'h1;
      t.st     = ST_SEND;
      return t;
   endfunction : send_load

   // Idle: the engine ignores SCL and waits for a start.
   // A stop parks the pointer on the status register.
   // Both conditions override whatever phase is active.

   // Receive: eight SCL rises shift a byte in, MSB first.
   // The SCL fall after the eighth bit is the decision.
   // The kind field says how that byte is to be read:
   // address, pointer, data byte or general call.

   // An address for this port or the general call is
   // acknowledged; anything else drops back to idle.
   // While defaults reload every address is ignored, so
   // the master sees a missing acknowledge, not a stall.

   // Acknowledge: SDA is held low through the ninth pulse
   // and let go shortly after the following SCL fall.
   // Releasing late rather than early keeps SDA steady
   // while SCL is high, so no false stop is produced.

   // Writes: the pointer byte loads the pointer, then each
   // data byte is queued for the bank and the pointer moves.
   // Bytes past the last register are acknowledged but
   // never queued, so the bank sees valid addresses only.

   // A data byte that finds the last word still queued is
   // refused without acknowledge and keeps the pointer.
   // This trades a retry by the master for a small buffer;
   // no word is dropped silently for lack of room.

   // Reads: the bank answers the pointer in the same clock,
   // and each byte is fetched on the SCL fall opening it.
   // A master acknowledge moves the pointer on the SCL
   // rise, so the next fetch already sees the new address.
   // Reads run on past the bank; the bank decides what
   // unused addresses return.

   // Reset commands raise a one-cycle request to the bank
   // and start the busy timer; the command byte is still
   // acknowledged, then the engine goes idle.
   // Further bytes of the same transfer are ignored.

   // Line events lag the pins by two clocks, so SCL
   // high and low phases must each last several clocks.
   // A slower bus is fine; a faster one loses bits.

   // Clock enable low freezes the synchroniser too, so a
   // bus event that begins and ends while frozen is lost;
   // keep the enable high while the bus is active.

   // The pointer is eight bits wide and wraps to zero.

   // Reset leaves the engine idle, the pointer on the
   // status register and no write pending.

   // Engine next state; protocol decisions happen on synchronised SCL edges, starts and stops.
   always_comb begin
      next_r            = r;
      next_r.reload_req = 1'b0;

      // A queued write stays offered until the buffer takes it.
      if (r.push_valid && buf_ready) begin
         next_r.push_valid = 1'b0;
      end

      // Reload timer; acknowledges stay off until it runs out.
      if (r.reload_busy) begin
         if (r.reload_cnt <= 24'h000001) begin
            next_r.reload_busy = 1'b0;
            next_r.reload_cnt  = 24'h000000;
         end else begin
            next_r.reload_cnt = r.reload_cnt - 24'h000001;
         end
      end

      if (line.stop) begin
         // Stop ends any transfer and parks the pointer on the status register.
         next_r.st     = ST_IDLE;
         next_r.ptr    = `I2CSP_PTR_RESET;
         next_r.sda_oe = 1'b0;
      end else if (line.start) begin
         // Start and repeated start look the same: a new address byte follows.
         next_r.st     = ST_RECV;
         next_r.kind   = K_ADDR;
         next_r.bitcnt = 4'h0;
         next_r.sda_oe = 1'b0;
      end else begin
         unique case (r.st)
            ST_IDLE: begin
               next_r.sda_oe = 1'b0;
            end

            ST_RECV: begin
               if (line.scl_rise && r.bitcnt < 4'h8) begin
                  next_r.shreg  = {r.shreg[6:0], line.sda};
                  next_r.bitcnt = r.bitcnt + 4'h1;
               end else if (line.scl_fall && r.bitcnt == 4'h8) begin
                  next_r.bitcnt    = 4'h0;
                  next_r.after_ack = 1'b0;
                  next_r.st        = ST_IDLE;
                  unique case (r.kind)
                     K_ADDR: begin
                        // Busy reload or a foreign address leaves the bus alone.
                        if (!r.reload_busy) begin
                           if (r.shreg == `I2CSP_START_WR || r.shreg == `I2CSP_START_RD) begin
                              next_r.rw     = r.shreg[0];
                              next_r.kind   = K_PTR;
                              next_r.sda_oe = 1'b1;
                              next_r.st     = ST_ACK;
                           end else if (r.shreg == `I2CSP_START_GC) begin
                              next_r.rw     = 1'b0;
                              next_r.kind   = K_GC;
                              next_r.sda_oe = 1'b1;
                              next_r.st     = ST_ACK;
                           end
                        end
                     end
                     K_PTR: begin
                        next_r.sda_oe = 1'b1;
                        next_r.st     = ST_ACK;
                        if (r.shreg == `I2CSP_CMD_RESET) begin
                           next_r           = start_reload(next_r);
                           next_r.after_ack = 1'b1;
                        end else begin
                           next_r.ptr  = r.shreg;
                           next_r.kind = K_DATA;
                        end
                     end
                     K_DATA: begin
                        // A full buffer is the only reason to refuse a data byte.
                        if (!r.push_valid) begin
                           if (reg_writable(r.ptr)) begin
                              next_r.push_valid = 1'b1;
                              next_r.push.addr  = r.ptr;
                              next_r.push.data  = r.shreg;
                           end
                           next_r.sda_oe = 1'b1;
                           next_r.ptr    = r.ptr + 8'h01;
                           next_r.st     = ST_ACK;
                        end
                     end
                     K_GC: begin
                        if (r.shreg == `I2CSP_GC_RESET) begin
                           next_r           = start_reload(next_r);
                           next_r.sda_oe    = 1'b1;
                           next_r.after_ack = 1'b1;
                           next_r.st        = ST_ACK;
                        end
                        // Other commands fall to idle without acknowledge.
                     end
                  endcase
               end
            end

            ST_ACK: begin
               // Ninth pulse ends on this fall; hand SDA to the next phase.
               if (line.scl_fall) begin
                  next_r.sda_oe = 1'b0;
                  if (r.after_ack) begin
                     next_r.st = ST_IDLE;
                  end else if (r.rw) begin
                     next_r = send_load(next_r, rd_data);
                  end else begin
                     next_r.st = ST_RECV;
                  end
               end
            end

            ST_SEND: begin
               // The bank's data is sent; the pointer register is never a source.
               if (line.scl_fall) begin
                  if (r.bitcnt == 4'h8) begin
                     next_r.sda_oe = 1'b0;
                     next_r.st     = ST_MACK;
                  end else begin
                     next_r.sda_oe = ~r.shreg[7];
                     next_r.shreg  = {r.shreg[6:0], 1'b0};
                     next_r.bitcnt = r.bitcnt + 4'h1;
                  end
               end
            end

            ST_MACK: begin
               if (line.scl_rise) begin
                  if (!line.sda) begin
                     next_r.ptr = r.ptr + 8'h01;
                     next_r.st  = ST_RNEXT;
                  end else begin
                     next_r.st = ST_IDLE;
                  end
               end
            end

            ST_RNEXT: begin
               // Read data was looked up during the high phase at the new pointer.
               if (line.scl_fall) begin
                  next_r = send_load(next_r, rd_data);
               end
            end

            default: begin
               next_r.st     = ST_IDLE;
               next_r.sda_oe = 1'b0;
            end
         endcase
      end
   end

   // Clock enable freezes the engine together with its helpers.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         r <= '0;
      end else if (ce) begin
         r <= next_r;
      end
   end

   // Open drain: the pad only ever pulls low.
   assign sda_out     = 1'b0;
   assign sda_oe      = r.sda_oe;
   assign rd_addr     = r.ptr;
   assign wr_valid    = buf_out_valid;
   assign wr_word     = buf_out_data;
   assign reload_req  = r.reload_req;
   assign reload_busy = r.reload_busy;

endmodule : i2csp_port

// ---- bench/i2csp_port_assertions.sv ----
// Concurrent checks on the ports of the two-wire slave register port.
`timescale 1ns/10ps
module i2csp_port_checker
   import i2csp_pkg::*;
#(
   parameter int         RELOAD_CYCLES = 200000,
   parameter logic [7:0] LAST_REG      = 8'h17
) (
   input wire logic                 clk,
   input wire logic                 resetn,
   input wire logic                 ce,
   input wire logic                 scl_in,
   input wire logic                 sda_in,
   input wire logic                 sda_out,
   input wire logic                 sda_oe,
   input wire logic [7:0]           rd_addr,
   input wire logic [7:0]           rd_data,
   input wire logic                 wr_valid,
   input wire logic                 wr_ready,
   input wire i2csp_pkg::i2csp_wr_t wr_word,
   input wire logic                 reload_req,
   input wire logic                 reload_busy
);
   import i2csp_pkg::*;

   logic [23:0] busy_cnt;

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // Counts enabled busy cycles so the reload length can be checked without a long repetition.
   always_ff @(posedge clk) begin
      if (!resetn || !reload_busy) begin
         busy_cnt <= '0;
      end else if (ce) begin
         busy_cnt <= busy_cnt + 24'h000001;
      end
   end

   sequence scl_falls_s;
      ##[1:40] $fell(scl_in);
   endsequence

   sequence stop_s;
      scl_in && $past(scl_in) && $rose(sda_in);
   endsequence

   drive_open_a: assert property (sda_out == 1'b0)
      else $error("SDA data value is not low");
   ack_held_a: assert property ($rose(sda_oe) |-> sda_oe throughout scl_falls_s)
      else $error("SDA released before SCL fell");
   oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("SDA driver changed while SCL high");
   stop_ptr_a: assert property (stop_s |-> ##[1:6] (rd_addr == 8'h00))
      else $error("Pointer not cleared after stop");
   req_pulse_a: assert property (reload_req |=> !reload_req)
      else $error("Reload request longer than one cycle");
   req_busy_a: assert property (reload_req |-> ##[0:1] reload_busy)
      else $error("Reload request without busy");
   busy_len_a: assert property ($fell(reload_busy) |-> (busy_cnt == 24'(RELOAD_CYCLES)))
      else $error("Reload busy length wrong");
   busy_quiet_a: assert property ($past(reload_busy) && reload_busy |-> !$rose(sda_oe))
      else $error("Acknowledge during reload");
   wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_word))
      else $error("Write word lost while stalled");
   wr_range_a: assert property (wr_valid |-> (wr_word.addr <= LAST_REG))
      else $error("Write to invalid register passed on");
endmodule : i2csp_port_checker

bind i2csp_port i2csp_port_checker #(.RELOAD_CYCLES(RELOAD_CYCLES), .LAST_REG(LAST_REG)) i_i2csp_port_checker (
   .clk(clk), .resetn(resetn), .ce(ce), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
   .wr_word(wr_word), .reload_req(reload_req), .reload_busy(reload_busy));

// ---- bench/i2csp_master.sv ----
// Behavioural bus master: SCL of 160 ns, SDA pulled low open drain.
`timescale 1ns/10ps
module i2csp_master (
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   // SCL stands high between frames.
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   // A quarter of the bus period.
   task automatic qtr();
      repeat (4) @(posedge clk);
   endtask : qtr

   // Start or repeated start: SDA falls while SCL is high.
   task automatic start();
      sda_low <= 1'b0;
      qtr();
      scl <= 1'b1;
      qtr();
      sda_low <= 1'b1;
      qtr();
      scl <= 1'b0;
      qtr();
   endtask : start

   // Stop: SDA rises while SCL is high.
   task automatic stop();
      sda_low <= 1'b1;
      qtr();
      scl <= 1'b1;
      qtr();
      sda_low <= 1'b0;
      qtr();
   endtask : stop

   // Data set while SCL low, line sampled in the middle of the high phase.
   task automatic bit_xfer(input logic b, output logic r);
      sda_low <= ~b;
      qtr();
      scl <= 1'b1;
      qtr();
      r = sda;
      qtr();
      scl <= 1'b0;
      qtr();
   endtask : bit_xfer

   // Byte out MSB first, then the slave's acknowledge.
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], r);
      end
      bit_xfer(1'b1, r);
      ack = ~r;
   endtask : wbyte

   // Byte in MSB first, then our acknowledge or not.
   task automatic rbyte(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, d[i]);
      end
      bit_xfer(~mack, r);
   endtask : rbyte
endmodule : i2csp_master

// ---- bench/testbench.sv ----
// Self-checking bench of the two-wire slave register port.
`timescale 1ns/10ps
module testbench;
   import i2csp_pkg::*;

   logic        clk = 1'b0;
   logic        resetn;
   logic        ce;
   logic        scl;
   logic        sda_low;
   wire         sda;
   logic        sda_out;
   logic        sda_oe;
   logic [7:0]  rd_addr;
   wire  [7:0]  rd_data;
   logic        wr_valid;
   logic        wr_ready;
   i2csp_wr_t   wr_word;
   logic        reload_req;
   logic        reload_busy;
   logic [15:0] got[$];
   int          req_count = 0;
   int          err_count = 0;
   int          checked = 0;

   always #5 clk = ~clk;

   // Pull-up on SDA; either party pulls low. The bank answers with a pattern of the address.
   assign sda     = ~(sda_low | sda_oe);
   assign rd_data = rd_addr ^ 8'hA5;

   // Bank side: record every word taken and every reload request.
   always @(posedge clk) begin
      if (wr_valid && wr_ready) got.push_back(wr_word);
      if (reload_req) req_count++;
   end

   i2csp_port #(.RELOAD_CYCLES(400)) i_i2csp_port (
      .clk(clk), .resetn(resetn), .ce(ce), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .wr_word(wr_word), .reload_req(reload_req), .reload_busy(reload_busy));

   i2csp_master i_i2csp_master (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wrap_up();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   // Writes into a stalled bank until the buffer refuses, then drains it.
   task automatic write_stall();
      logic       a;
      logic [3:0] acks;
      logic [7:0] d [4] = '{8'hAA, 8'h55, 8'h33, 8'h0C};
      wr_ready <= 1'b0;
      i_i2csp_master.start();
      i_i2csp_master.wbyte(8'h90, a);
      chk("write address ack", a, 1'b1);
      chk("open drain data", sda_out, 1'b0);
      i_i2csp_master.wbyte(8'h05, a);
      chk("pointer ack", a, 1'b1);
      chk("pointer load", rd_addr, 8'h05);
      for (int i = 0; i < 4; i++) i_i2csp_master.wbyte(d[i], acks[i]);
      chk("three acks", acks[2:0], 3'b111);
      chk("full buffer refuses", acks[3], 1'b0);
      chk("refused keeps pointer", rd_addr, 8'h08);
      i_i2csp_master.stop();
      repeat (4) @(posedge clk);
      chk("pointer after stop", rd_addr, 8'h00);
      wr_ready <= 1'b1;
      repeat (8) @(posedge clk);
      chk("words taken", 16'(got.size()), 16'd3);
      for (int i = 0; i < got.size(); i++) chk("stored word", got[i], {8'h05 + 8'(i), d[i]});
      got.delete();
   endtask : write_stall

   // Second byte lands past the last register: acknowledged but dropped.
   task automatic write_invalid();
      logic [3:0] a;
      i_i2csp_master.start();
      i_i2csp_master.wbyte(8'h90, a[0]);
      i_i2csp_master.wbyte(8'h17, a[1]);
      i_i2csp_master.wbyte(8'h11, a[2]);
      i_i2csp_master.wbyte(8'h22, a[3]);
      i_i2csp_master.stop();
      repeat (8) @(posedge clk);
      chk("invalid write acks", a, 4'hF);
      chk("valid words only", 16'(got.size()), 16'd1);
      chk("last register word", got[0], 16'h1711);
      got.delete();
   endtask : write_invalid

   // Pointer, repeated start, multibyte read past the range, then polling after stop.
   task automatic read_seq();
      logic       a;
      logic [7:0] d;
      i_i2csp_master.start();
      i_i2csp_master.wbyte(8'h90, a);
      i_i2csp_master.wbyte(8'h16, a);
      i_i2csp_master.start();
      i_i2csp_master.wbyte(8'h91, a);
      chk("read address ack", a, 1'b1);
      for (int i = 0; i < 3; i++) begin
         i_i2csp_master.rbyte(i < 2, d);
         chk("read byte", d, (8'h16 + 8'(i)) ^ 8'hA5);
      end
      chk("no increment on nack", rd_addr, 8'h18);
      i_i2csp_master.start();
      i_i2csp_master.wbyte(8'h91, a);
      i_i2csp_master.rbyte(1'b0, d);
      chk("read past range", d, 8'h18 ^ 8'hA5);
      i_i2csp_master.stop();
      i_i2csp_master.start();
      i_i2csp_master.wbyte(8'h91, a);
      i_i2csp_master.rbyte(1'b0, d);
      chk("status after stop", d, 8'hA5);
      i_i2csp_master.stop();
   endtask : read_seq

   // Foreign addresses and a foreign general call command are not acknowledged.
   task automatic miss();
      logic       a;
      logic [7:0] adr [3] = '{8'h92, 8'h20, 8'h01};
      for (int i = 0; i < 3; i++) begin
         i_i2csp_master.start();
         i_i2csp_master.wbyte(adr[i], a);
         chk("foreign address", a, 1'b0);
         i_i2csp_master.stop();
      end
      i_i2csp_master.start();
      i_i2csp_master.wbyte(8'h00, a);
      chk("general call ack", a, 1'b1);
      i_i2csp_master.wbyte(8'h07, a);
      chk("other command", a, 1'b0);
      i_i2csp_master.stop();
      chk("no reload", 16'(req_count), 16'd0);
   endtask : miss

   // Both reset commands: reload, silence while busy, answer afterwards.
   task automatic reset_cmds();
      logic        a;
      logic [7:0]  d;
      int          n;
      int          k;
      logic [15:0] cmd [2] = '{16'h90BF, 16'h0006};
      for (int i = 0; i < 2; i++) begin
         n = req_count;
         i_i2csp_master.start();
         i_i2csp_master.wbyte(cmd[i][15:8], a);
         i_i2csp_master.wbyte(cmd[i][7:0], a);
         chk("command ack", a, 1'b1);
         i_i2csp_master.stop();
         chk("reload pulse", 16'(req_count - n), 16'd1);
         i_i2csp_master.start();
         i_i2csp_master.wbyte(8'h91, a);
         chk("silent while busy", a, 1'b0);
         i_i2csp_master.stop();
         ce <= 1'b0;
         repeat (300) @(posedge clk);
         chk("busy frozen", reload_busy, 1'b1);
         ce <= 1'b1;
         for (k = 0; k < 2000 && reload_busy !== 1'b0; k++) @(posedge clk);
         chk("reload ends", reload_busy, 1'b0);
         i_i2csp_master.start();
         i_i2csp_master.wbyte(8'h91, a);
         chk("ack after reload", a, 1'b1);
         i_i2csp_master.rbyte(1'b0, d);
         chk("status after reload", d, 8'hA5);
         i_i2csp_master.stop();
      end
   endtask : reset_cmds

   initial begin
      resetn   = 1'b0;
      ce       = 1'b1;
      wr_ready = 1'b1;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      write_stall();
      write_invalid();
      read_seq();
      miss();
      reset_cmds();
      wrap_up();
   end

   // Cuts a hang short well beyond the expected run of some 6500 cycles.
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      wrap_up();
   end
endmodule : testbench
